/* File: src/rtcf_top.sv */
// rtc event flags, interrupt output, stop bit and external clock test mode
// Notes on behaviour
// [R1] tick and countdown events set their flags
// [R2] flags hold until a write or the minute-only auto-clear; reads harmless
// [R3] flag write stores and of old, written
// [R4] flags at bits five, three and two
// [R5] host rewrites control bits when clearing flags
// [R6] alarm flag clears by the same and-write
// [R7] one active-low wired-or interrupt, three sources
// [R8] pulse select: pulses or flag-following levels
// [R9] tick pulse lasts one 64 Hz period
// [R10] clearing tick flag ends its pulse
// [R11] level mode: both enables zero release
// [R12] countdown reaches interrupt only when enabled
// [R13] countdown pulse width from source and value
// [R14] clearing countdown flag ends its pulse
// [R15] level mode: countdown enable zero releases
// [R16] alarm interrupt follows alarm flag level only
// [R17] test bit turns clock pin into input
// [R18] test clock divided by 2^6 to 1 Hz
// [R19] first tick edge 32, then every 64
// [R20] stop resets upper prescaler, no ticks
// [R21] stop leaves fast clock outputs running
// [R22] host toggles stop after entering test mode
// [R23] minute or second enable picks flag event
// [R24] minute-only mode auto-clears flag after second
// [R25] interrupt released when no source asserts
`timescale 1ns/1ps
`default_nettype none
module rtcf_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire rtcf_pkg::rtcf_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  input wire logic osc_in,
  input wire logic clock_output_pin_in,
  output logic clock_output_pin_out,
  output logic clock_output_pin_oe,
  input wire logic [1:0] clock_output_pin_freq_sel,
  input wire logic minute_inc,
  input wire logic alarm_match,
  input wire logic countdown_done,
  input wire logic countdown_t_is_one,
  input wire logic [1:0] countdown_src,
  output rtcf_pkg::rtcf_ticks_type time_ticks,
  output logic int_pin_out,
  output logic int_pin_oe
);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  function automatic logic reg_hit(input rtcf_pkg::rtcf_reg_req_type req,
                                   input logic [3:0] addr);
    reg_hit = req.addr == addr;
  endfunction

  // pin synchronisers
  logic [1:0] osc_sync;
  logic [1:0] ext_sync;
  logic osc_last;
  logic ext_last;
  logic osc_rise;
  logic ext_rise;

  logic [7:0] ctrl1;
  logic [7:0] next_ctrl1;
  rtcf_pkg::rtcf_ctrl2_type ctrl2;
  rtcf_pkg::rtcf_ctrl2_type next_ctrl2;
  logic wr_ctl1;
  logic wr_ctl2;
  logic [7:0] wd;
  logic [7:0] next_rdata;

  logic external_clock_test_select;
  logic stop_bit;
  logic pulse_mode;
  logic [rtcf_pkg::PRESC_KEEP_STAGES-1:0] low_stages;
  rtcf_pkg::rtcf_ticks_type presc_ticks;
  logic sec_tick;

  logic minute_only;
  logic minute_evt;
  logic msf_event;
  logic msf_auto_armed;
  logic next_auto_armed;
  logic msf_auto_clear;
  logic keep_tick_flag;
  logic keep_alarm_flag;
  logic keep_cd_flag;

  logic ms_start;
  logic ms_cancel;
  logic ms_active;
  logic cd_start;
  logic cd_cancel;
  logic cd_tick;
  logic cd_active;
  logic ms_src;
  logic cd_src;
  logic al_src;
  logic next_int_oe;
  logic next_clk_level;

  // input edges, read from the second synchroniser stage only
  assign osc_rise = osc_sync[1] & ~osc_last;
  assign ext_rise = ext_sync[1] & ~ext_last;

  assign external_clock_test_select = ctrl1[rtcf_pkg::CTRL1_EXTERNAL_CLOCK_TEST_SELECT_BIT];
  assign stop_bit = ctrl1[rtcf_pkg::CTRL1_STOP_BIT];
  assign pulse_mode = ctrl2.timer_irq_pulse_select;

  // register decode
  assign wd = reg_req.wdata;
  assign wr_ctl1 = reg_req.wr & reg_hit(reg_req, rtcf_pkg::ADDR_CTRL1);
  assign wr_ctl2 = reg_req.wr & reg_hit(reg_req, rtcf_pkg::ADDR_CTRL2);
  assign next_ctrl1 = wr_ctl1 ? (wd & rtcf_pkg::CTRL1_MASK) : ctrl1;
  assign next_rdata = !reg_req.rd ? reg_rdata :
                      reg_hit(reg_req, rtcf_pkg::ADDR_CTRL1) ? ctrl1 :
                      reg_hit(reg_req, rtcf_pkg::ADDR_CTRL2) ? ctrl2 : 8'h00;

  // a written one keeps a flag, a written zero clears it
  assign keep_tick_flag = ~wr_ctl2 | wd[rtcf_pkg::CTRL2_TICK_FLAG_BIT]; // [R3] [R4]
  assign keep_alarm_flag = ~wr_ctl2 | wd[rtcf_pkg::CTRL2_ALARM_FLAG_BIT]; // [R6]
  assign keep_cd_flag = ~wr_ctl2 | wd[rtcf_pkg::CTRL2_CD_FLAG_BIT]; // [R3]

  // flag events
  assign sec_tick = presc_ticks.tick_1hz;
  assign minute_only = ctrl2.minute_tick_enable & ~ctrl2.second_tick_enable;
  assign minute_evt = minute_only & minute_inc;
  assign msf_event = (ctrl2.second_tick_enable & sec_tick) | minute_evt; // [R23]
  assign next_auto_armed = minute_evt | (msf_auto_armed & ~sec_tick);
  assign msf_auto_clear = msf_auto_armed & sec_tick & minute_only; // [R24]

  // event set wins over a clear in the same cycle; reads never touch flags
  assign next_ctrl2 = '{ // [R1] [R2] [R5]
    minute_tick_enable: wr_ctl2 ? wd[rtcf_pkg::CTRL2_MINUTE_EN_BIT] : ctrl2.minute_tick_enable,
    second_tick_enable: wr_ctl2 ? wd[rtcf_pkg::CTRL2_SECOND_EN_BIT] : ctrl2.second_tick_enable,
    periodic_tick_flag:
      (ctrl2.periodic_tick_flag & keep_tick_flag & ~msf_auto_clear) | msf_event,
    timer_irq_pulse_select:
      wr_ctl2 ? wd[rtcf_pkg::CTRL2_PULSE_SEL_BIT] : ctrl2.timer_irq_pulse_select,
    alarm_match_flag: (ctrl2.alarm_match_flag & keep_alarm_flag) | alarm_match,
    countdown_done_flag: (ctrl2.countdown_done_flag & keep_cd_flag) | countdown_done,
    alarm_irq_enable: wr_ctl2 ? wd[rtcf_pkg::CTRL2_ALARM_IE_BIT] : ctrl2.alarm_irq_enable,
    countdown_irq_enable: wr_ctl2 ? wd[rtcf_pkg::CTRL2_CD_IE_BIT] : ctrl2.countdown_irq_enable
  };

  // pulse generators
  assign ms_start = msf_event & pulse_mode; // [R8]
  assign ms_cancel = ~pulse_mode | ~keep_tick_flag; // [R10]
  assign cd_start = countdown_done & pulse_mode & ctrl2.countdown_irq_enable;
  assign cd_cancel = ~pulse_mode | ~keep_cd_flag | ~ctrl2.countdown_irq_enable; // [R14]
  assign cd_tick = (countdown_src == rtcf_pkg::CD_SRC_4096HZ) ? // [R13]
                   (countdown_t_is_one ? presc_ticks.tick_8192hz : presc_ticks.tick_4096hz) :
                   (countdown_src == rtcf_pkg::CD_SRC_64HZ) ?
                   (countdown_t_is_one ? presc_ticks.tick_128hz : presc_ticks.tick_64hz) :
                   presc_ticks.tick_64hz;

  // interrupt sources, wired together
  assign ms_src = pulse_mode ? ms_active : // [R8]
                  (ctrl2.periodic_tick_flag &
                   (ctrl2.minute_tick_enable | ctrl2.second_tick_enable)); // [R11]
  assign cd_src = ctrl2.countdown_irq_enable & // [R12] [R15]
                  (pulse_mode ? cd_active : ctrl2.countdown_done_flag);
  assign al_src = ctrl2.alarm_irq_enable & ctrl2.alarm_match_flag; // [R16]
  assign next_int_oe = ms_src | cd_src | al_src; // [R7] [R25]

  assign next_clk_level = (clock_output_pin_freq_sel == rtcf_pkg::CLOCK_OUTPUT_PIN_SEL_32K) ? osc_sync[1] :
                          (clock_output_pin_freq_sel == rtcf_pkg::CLOCK_OUTPUT_PIN_SEL_16K) ? low_stages[0] :
                          (clock_output_pin_freq_sel == rtcf_pkg::CLOCK_OUTPUT_PIN_SEL_8K) ? low_stages[1] :
                          1'b0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_sync <= 2'h0;
      ext_sync <= 2'h0;
      osc_last <= 1'b0;
      ext_last <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[0], osc_in};
      ext_sync <= {ext_sync[0], clock_output_pin_in};
      osc_last <= osc_sync[1];
      ext_last <= ext_sync[1];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl1 <= rtcf_pkg::CTRL1_RESET;
      ctrl2 <= rtcf_pkg::CTRL2_RESET;
      msf_auto_armed <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      ctrl1 <= next_ctrl1;
      ctrl2 <= next_ctrl2;
      msf_auto_armed <= next_auto_armed;
      reg_rdata <= next_rdata;
    end
  end

  // pin drivers; the interrupt pin only ever pulls low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_pin_out <= 1'b0;
      int_pin_oe <= 1'b0;
      clock_output_pin_out <= 1'b0;
      clock_output_pin_oe <= 1'b1;
      time_ticks <= '0;
    end else begin
      int_pin_out <= 1'b0;
      int_pin_oe <= next_int_oe; // [R7]
      clock_output_pin_out <= next_clk_level; // [R21]
      clock_output_pin_oe <= ~external_clock_test_select; // [R17]
      time_ticks <= presc_ticks;
    end
  end

  // test mode swaps the oscillator for the clock pin
  rtcf_prescaler #(
    .WIDTH(rtcf_pkg::PRESC_WIDTH)
  ) u_prescaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .osc_step(osc_rise & ~external_clock_test_select), // [R17]
    .ext_step(ext_rise & external_clock_test_select), // [R18]
    .stop(stop_bit), // [R20]
    .low_stages(low_stages),
    .ticks(presc_ticks)
  );

  rtcf_pulse_gen u_ms_pulse (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(ms_start),
    .tick(presc_ticks.tick_64hz), // [R9]
    .cancel(ms_cancel),
    .active(ms_active)
  );

  rtcf_pulse_gen u_cd_pulse (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(cd_start),
    .tick(cd_tick),
    .cancel(cd_cancel),
    .active(cd_active)
  );

  AST_TICK_FLAG_SET: assert property ( // [R1]
    msf_event |=> ctrl2.periodic_tick_flag)
    else $error("tick event did not set its flag");

  AST_CD_FLAG_SET: assert property ( // [R1]
    countdown_done |=> ctrl2.countdown_done_flag)
    else $error("countdown end did not set its flag");

  AST_READ_KEEPS_FLAGS: assert property ( // [R2]
    !reg_req.wr && !msf_event && !msf_auto_clear && !alarm_match && !countdown_done
    |=> $stable(ctrl2))
    else $error("flags changed without a write or event");

  AST_CD_AND_WRITE: assert property ( // [R3]
    wr_ctl2 && !countdown_done |=> ctrl2.countdown_done_flag ==
    ($past(ctrl2.countdown_done_flag) & $past(reg_req.wdata[rtcf_pkg::CTRL2_CD_FLAG_BIT])))
    else $error("countdown flag write is not an and");

  AST_ALARM_AND_WRITE: assert property ( // [R6]
    wr_ctl2 && !alarm_match |=> ctrl2.alarm_match_flag ==
    ($past(ctrl2.alarm_match_flag) & $past(reg_req.wdata[rtcf_pkg::CTRL2_ALARM_FLAG_BIT])))
    else $error("alarm flag write is not an and");

  AST_ALARM_LEVEL: assert property ( // [R16]
    ctrl2.alarm_irq_enable && ctrl2.alarm_match_flag |=> int_pin_oe)
    else $error("alarm flag did not pull the interrupt");

  AST_ALARM_CLEAR_RELEASE: assert property ( // [R16]
    (wr_ctl2 && !wd[rtcf_pkg::CTRL2_ALARM_FLAG_BIT] && !alarm_match)
    ##1 (!ms_src && !cd_src) |=> !int_pin_oe)
    else $error("alarm clear did not release the interrupt");

  AST_CD_GATED: assert property ( // [R12] [R25]
    !ctrl2.countdown_irq_enable && !ms_src && !al_src |=> !int_pin_oe)
    else $error("disabled countdown reached the interrupt");

  AST_LEVEL_MS_RELEASE: assert property ( // [R11]
    (!pulse_mode && wr_ctl2 && !wd[rtcf_pkg::CTRL2_PULSE_SEL_BIT] &&
     !wd[rtcf_pkg::CTRL2_MINUTE_EN_BIT] && !wd[rtcf_pkg::CTRL2_SECOND_EN_BIT])
    ##1 (!cd_src && !al_src) |=> !int_pin_oe)
    else $error("level tick interrupt not released");

  AST_MS_PULSE_WIDTH: assert property ( // [R9]
    ms_start ##1 (!presc_ticks.tick_64hz && !ms_cancel) |-> ms_active)
    else $error("tick pulse ended before its period");

  AST_CD_SHORTEN: assert property ( // [R14]
    wr_ctl2 && !wd[rtcf_pkg::CTRL2_CD_FLAG_BIT] && !cd_start |=> !cd_active)
    else $error("countdown pulse not shortened");

  AST_AUTO_CLEAR: assert property ( // [R24]
    msf_auto_clear && !msf_event |=> !ctrl2.periodic_tick_flag)
    else $error("minute-only flag not cleared after a second");

  AST_TEST_PIN_INPUT: assert property ( // [R17]
    external_clock_test_select |=> !clock_output_pin_oe)
    else $error("clock pin driven in test mode");

  AST_STOP_NO_TICK: assert property ( // [R20]
    $past(stop_bit) |-> !presc_ticks.tick_1hz)
    else $error("1 Hz tick during stop");

  COV_MS_PULSE: cover property (ms_start ##1 ms_active ##[1:300] !ms_active);
  COV_CD_LEVEL: cover property (!pulse_mode && cd_src ##1 int_pin_oe);
  COV_ALARM_INT: cover property (al_src ##1 int_pin_oe ##[1:50] !int_pin_oe);
  COV_TEST_TICK: cover property (external_clock_test_select && presc_ticks.tick_1hz);

endmodule
`default_nettype wire

/* File: src/rtcf_pkg.sv */
// shared constants and carrier types for the rtc flag and interrupt block
package rtcf_pkg;

  // register addresses
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h1;

  // first control register layout
  localparam int CTRL1_EXTERNAL_CLOCK_TEST_SELECT_BIT = 7;
  localparam int CTRL1_STOP_BIT = 5;
  localparam logic [7:0] CTRL1_MASK = 8'hEC;
  localparam logic [7:0] CTRL1_RESET = 8'h08;

  // second control register layout
  localparam int CTRL2_MINUTE_EN_BIT = 7;
  localparam int CTRL2_SECOND_EN_BIT = 6;
  localparam int CTRL2_TICK_FLAG_BIT = 5;
  localparam int CTRL2_PULSE_SEL_BIT = 4;
  localparam int CTRL2_ALARM_FLAG_BIT = 3;
  localparam int CTRL2_CD_FLAG_BIT = 2;
  localparam int CTRL2_ALARM_IE_BIT = 1;
  localparam int CTRL2_CD_IE_BIT = 0;
  localparam logic [7:0] CTRL2_RESET = 8'h00;

  // prescaler: stage k of the counter is prescaler stage F(k)
  localparam int PRESC_WIDTH = 15;
  localparam int PRESC_KEEP_STAGES = 2;
  localparam int PRESC_BIT_8192HZ = 2;
  localparam int PRESC_BIT_4096HZ = 3;
  localparam int PRESC_BIT_128HZ = 8;
  localparam int PRESC_BIT_64HZ = 9;
  localparam int PRESC_BIT_1HZ = 14;
  // external test clock enters at the foot of a 2^6 chain that ends at the 1 Hz stage
  localparam int TEST_STEP_BIT = PRESC_BIT_1HZ + 1 - 6;

  // countdown source clock select
  localparam logic [1:0] CD_SRC_4096HZ = 2'h0;
  localparam logic [1:0] CD_SRC_64HZ = 2'h1;

  // clock output frequency select
  localparam logic [1:0] CLOCK_OUTPUT_PIN_SEL_32K = 2'h0;
  localparam logic [1:0] CLOCK_OUTPUT_PIN_SEL_16K = 2'h1;
  localparam logic [1:0] CLOCK_OUTPUT_PIN_SEL_8K = 2'h2;

  typedef struct packed {
    logic minute_tick_enable;
    logic second_tick_enable;
    logic periodic_tick_flag;
    logic timer_irq_pulse_select;
    logic alarm_match_flag;
    logic countdown_done_flag;
    logic alarm_irq_enable;
    logic countdown_irq_enable;
  } rtcf_ctrl2_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtcf_reg_req_type;

  typedef struct packed {
    logic tick_1hz;
    logic tick_64hz;
    logic tick_128hz;
    logic tick_4096hz;
    logic tick_8192hz;
  } rtcf_ticks_type;

endpackage

/* File: src/rtcf_pulse_gen.sv */
// interrupt pulse stretcher that ends on the next selected tick
`timescale 1ns/1ps
`default_nettype none
module rtcf_pulse_gen (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic tick,
  input wire logic cancel,
  output logic active
);

  logic next_active;

  // a start wins over a cancel or tick in the same cycle
  assign next_active = start | (active & ~tick & ~cancel);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
    end else begin
      active <= next_active;
    end
  end

  AST_PULSE_ENDS_ON_TICK: assert property ( // [R9]
    @(posedge ref_clk) disable iff (rst)
    active && tick && !start |=> !active)
    else $error("pulse outlived its tick");

  AST_PULSE_CANCEL: assert property ( // [R10]
    @(posedge ref_clk) disable iff (rst)
    active && cancel && !start |=> !active)
    else $error("pulse not shortened on cancel");

endmodule
`default_nettype wire

/* File: src/rtcf_prescaler.sv */
// oscillator prescaler with stop reset of the upper stages and test clock entry
`timescale 1ns/1ps
`default_nettype none
module rtcf_prescaler #(
  parameter int WIDTH = rtcf_pkg::PRESC_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic osc_step,
  input wire logic ext_step,
  input wire logic stop,
  output logic [rtcf_pkg::PRESC_KEEP_STAGES-1:0] low_stages,
  output rtcf_pkg::rtcf_ticks_type ticks
);

  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
  localparam logic [WIDTH-1:0] EXT_INC = ONE << rtcf_pkg::TEST_STEP_BIT;
  localparam logic [WIDTH-1:0] LOW_MASK = (ONE << rtcf_pkg::PRESC_KEEP_STAGES) - ONE;

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] step_amount;
  logic [WIDTH-1:0] sum;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] changed;

  // test clock edges feed the 2^6 chain directly
  assign step_amount = ext_step ? EXT_INC : (osc_step ? ONE : '0); // [R18] [R19]
  assign sum = count + step_amount;
  // stop clears the upper stages, the two lowest keep running
  assign next_count = stop ? (sum & LOW_MASK) : sum; // [R20] [R21]
  assign changed = count ^ next_count;
  assign low_stages = count[rtcf_pkg::PRESC_KEEP_STAGES-1:0];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      ticks <= '0;
    end else begin
      count <= next_count;
      ticks <= '{
        tick_1hz: ~stop & ~count[rtcf_pkg::PRESC_BIT_1HZ] & next_count[rtcf_pkg::PRESC_BIT_1HZ],
        tick_64hz: ~stop & changed[rtcf_pkg::PRESC_BIT_64HZ],
        tick_128hz: ~stop & changed[rtcf_pkg::PRESC_BIT_128HZ],
        tick_4096hz: ~stop & changed[rtcf_pkg::PRESC_BIT_4096HZ],
        tick_8192hz: ~stop & changed[rtcf_pkg::PRESC_BIT_8192HZ]
      };
    end
  end

  AST_STOP_HOLDS_UPPER: assert property ( // [R20]
    @(posedge ref_clk) disable iff (rst)
    stop |=> (count & ~LOW_MASK) == '0)
    else $error("upper prescaler stages not held in stop");

  AST_LOW_RUN_IN_STOP: assert property ( // [R21]
    @(posedge ref_clk) disable iff (rst)
    stop && osc_step && !ext_step |=> count[0] != $past(count[0]))
    else $error("lowest prescaler stage halted by stop");

endmodule
`default_nettype wire

/* File: verif/rtcf_host_model.sv */
// host side model: register access and external test clock source
`timescale 1ns/1ps
`default_nettype none
module rtcf_host_model (
  input wire logic ref_clk,
  output var rtcf_pkg::rtcf_reg_req_type reg_req,
  output var logic ext_clk
);
  initial begin
    reg_req = '0;
    ext_clk = 1'b0;
  end

  // one strobe cycle, then the bus is released for one cycle
  task automatic reg_access(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  // flags to clear get 0, other flags 1, control bits their kept values
  task automatic clear_flags(input logic [7:0] ctrl, input logic [7:0] clr);
    reg_access(1'b1, rtcf_pkg::ADDR_CTRL2, (ctrl & 8'hD3) | (8'h2C & ~clr));
  endtask

  // prescaler state is unknown on entry, so stop is pulsed
  task automatic enter_test();
    reg_access(1'b1, rtcf_pkg::ADDR_CTRL1, 8'h80);
    reg_access(1'b1, rtcf_pkg::ADDR_CTRL1, 8'hA0);
    reg_access(1'b1, rtcf_pkg::ADDR_CTRL1, 8'h80);
  endtask

  task automatic ext_edges(input int n);
    repeat (n) begin
      repeat (4) @(posedge ref_clk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_clk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_rtcf_top.sv */
// self-checking bench for the rtc flag, interrupt, stop and test mode block
`timescale 1ns/1ps
`default_nettype none
module tb_rtcf_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  rtcf_pkg::rtcf_reg_req_type reg_req;
  rtcf_pkg::rtcf_ticks_type time_ticks;
  logic [7:0] reg_rdata;
  logic osc_in = 1'b0;
  logic ext_clk, pin_out, pin_oe, int_pin_out, int_pin_oe;
  logic [1:0] clock_output_pin_freq_sel = 2'h0;
  logic [1:0] countdown_src = 2'h0;
  logic minute_inc = 1'b0;
  logic alarm_match = 1'b0;
  logic countdown_done = 1'b0;
  logic t_is_one = 1'b0;
  wire logic pin_level = pin_oe ? pin_out : ext_clk;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  int bad_count = 0;
  int num_checks = 0;
  int ticks = 0;
  int seed;
  int w, t0, tg;
  logic [7:0] v;
  int per[6] = '{32, 64, 2048, 4096, 4096, 4096};
  logic [1:0] srcs[6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
  logic t1s[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  rtcf_host_model host (.ref_clk(ref_clk), .reg_req(reg_req), .ext_clk(ext_clk));

  rtcf_top dut (
    .ref_clk(ref_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .osc_in(osc_in), .clock_output_pin_in(pin_level), .clock_output_pin_out(pin_out),
    .clock_output_pin_oe(pin_oe), .clock_output_pin_freq_sel(clock_output_pin_freq_sel),
    .minute_inc(minute_inc), .alarm_match(alarm_match), .countdown_done(countdown_done),
    .countdown_t_is_one(t_is_one), .countdown_src(countdown_src),
    .time_ticks(time_ticks), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe)
  );

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // oscillator sped up: one rising edge every 8 cycles
  initial begin
    forever begin
      repeat (4) @(posedge ref_clk);
      osc_in <= ~osc_in;
    end
  end

  always @(posedge ref_clk) begin
    if (time_ticks.tick_1hz === 1'b1) ticks <= ticks + 1;
  end

  // read results are matched against the oldest noted expectation
  always @(posedge ref_clk) begin
    if (rd_d) begin
      num_checks++;
      if (exp_q.size() == 0 || reg_rdata !== exp_q[0]) begin
        bad_count++;
        $display("CHECK FAILED at %0t: read data %h", $time, reg_rdata);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    rd_d <= reg_req.rd;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.reg_access(1'b0, a, 8'h00);
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic wr2(input logic [7:0] d);
    host.reg_access(1'b1, rtcf_pkg::ADDR_CTRL2, d);
  endtask

  // k: 0 minute, 1 alarm, 2 countdown event
  task automatic ev(input int k);
    @(posedge ref_clk);
    minute_inc <= (k == 0);
    alarm_match <= (k == 1);
    countdown_done <= (k == 2);
    @(posedge ref_clk);
    {minute_inc, alarm_match, countdown_done} <= 3'b000;
  endtask

  task automatic wait_oe(input logic e, input int n);
    for (int i = 0; i < n && int_pin_oe !== e; i++) @(posedge ref_clk);
    chk(int_pin_oe, e);
    if (int_pin_oe !== e) summarize();
  endtask

  task automatic wait_tick(input int p);
    for (int i = 0; i < 6000; i++) begin
      @(posedge ref_clk);
      if (p == 32 && time_ticks.tick_8192hz === 1'b1) return;
      if (p == 64 && time_ticks.tick_4096hz === 1'b1) return;
      if (p == 2048 && time_ticks.tick_128hz === 1'b1) return;
      if (p == 4096 && time_ticks.tick_64hz === 1'b1) return;
    end
    chk(1'b0, 1'b1);
    summarize();
  endtask

  initial begin
    seed = 88136;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd_exp(rtcf_pkg::ADDR_CTRL1, rtcf_pkg::CTRL1_RESET);
    rd_exp(rtcf_pkg::ADDR_CTRL2, rtcf_pkg::CTRL2_RESET);
    rd_exp(4'h5, 8'h00);
    repeat (4) begin
      v = $random(seed);
      host.reg_access(1'b1, 4'h9, ~v);
      host.reg_access(1'b1, rtcf_pkg::ADDR_CTRL1, v);
      rd_exp(rtcf_pkg::ADDR_CTRL1, v & rtcf_pkg::CTRL1_MASK);
    end
    host.reg_access(1'b1, rtcf_pkg::ADDR_CTRL1, 8'h08);
    wr2(8'h80);
    ev(0);
    ev(1);
    ev(2);
    rd_exp(rtcf_pkg::ADDR_CTRL2, 8'hAC);
    rd_exp(rtcf_pkg::ADDR_CTRL2, 8'hAC);
    wr2(8'hA8);
    rd_exp(rtcf_pkg::ADDR_CTRL2, 8'hA8);
    wr2(8'h88);
    rd_exp(rtcf_pkg::ADDR_CTRL2, 8'h88);
    wr2(8'h80);
    rd_exp(rtcf_pkg::ADDR_CTRL2, 8'h80);
    wr2(8'h02);
    repeat (2) @(posedge ref_clk);
    chk(int_pin_oe, 1'b0);
    ev(1);
    wait_oe(1'b1, 4);
    chk(int_pin_out, 1'b0);
    host.clear_flags(8'h02, 8'h08);
    wait_oe(1'b0, 4);
    wr2(8'h00);
    ev(1);
    ev(2);
    repeat (4) @(posedge ref_clk);
    chk(int_pin_oe, 1'b0);
    wr2(8'h05);
    wait_oe(1'b1, 4);
    wr2(8'h04);
    wait_oe(1'b0, 4);
    wr2(8'h80);
    ev(0);
    wait_oe(1'b1, 4);
    wr2(8'h20);
    wait_oe(1'b0, 4);
    wr2(8'h00);
    for (int r = 0; r < 6; r++) begin
      countdown_src <= srcs[r];
      t_is_one <= t1s[r];
      tg = (r == 5) ? 8'h90 : 8'h11;
      wr2(tg);
      wait_tick(per[r]);
      ev((r == 5) ? 0 : 2);
      wait_oe(1'b1, 6);
      w = 0;
      while (int_pin_oe === 1'b1 && w < 5000) begin
        @(posedge ref_clk);
        w++;
      end
      chk(w >= per[r] - 8 && w <= per[r] + 2, 1'b1);
      host.clear_flags(tg, 8'h2C);
    end
    wr2(8'h11);
    ev(2);
    wait_oe(1'b1, 6);
    host.clear_flags(8'h11, 8'h04);
    wait_oe(1'b0, 4);
    wr2(8'h90);
    ev(0);
    wait_oe(1'b1, 6);
    host.clear_flags(8'h90, 8'h20);
    wait_oe(1'b0, 4);
    wr2(8'h00);
    host.reg_access(1'b1, rtcf_pkg::ADDR_CTRL1, 8'h28);
    // every clock output select, counted over 64 cycles while stopped
    for (int s = 0; s < 4; s++) begin
      clock_output_pin_freq_sel <= 2'(s);
      tg = (s == 3) ? 0 : (16 >> s);
      w = 0;
      repeat (64) begin
        @(posedge ref_clk);
        v[0] = pin_out;
        #1;
        if (pin_out !== v[0]) w++;
      end
      chk(w >= tg - 1 && w <= tg + 1, 1'b1);
    end
    host.enter_test();
    chk(pin_oe, 1'b0);
    wr2(8'h80);
    ev(0);
    t0 = ticks;
    host.ext_edges(31);
    repeat (8) @(posedge ref_clk);
    chk(ticks == t0, 1'b1);
    rd_exp(rtcf_pkg::ADDR_CTRL2, 8'hA0);
    host.ext_edges(1);
    repeat (8) @(posedge ref_clk);
    chk(ticks == t0 + 1, 1'b1);
    rd_exp(rtcf_pkg::ADDR_CTRL2, 8'h80);
    host.ext_edges(63);
    repeat (8) @(posedge ref_clk);
    chk(ticks == t0 + 1, 1'b1);
    host.ext_edges(1);
    repeat (8) @(posedge ref_clk);
    chk(ticks == t0 + 2, 1'b1);
    host.reg_access(1'b1, rtcf_pkg::ADDR_CTRL1, 8'hA0);
    host.ext_edges(64);
    repeat (8) @(posedge ref_clk);
    chk(ticks == t0 + 2, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
